// ---- src/tag_cmd_pkg.sv ----
// Shared constants and types for the tag memory command handler.
package tag_cmd_pkg;
    // Clock and the wait times, in nanoseconds and microseconds.
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_WRESP_US    = 10;
    localparam int T_WSC_US      = 10;
    localparam int T_PROG_US     = 5000;
    localparam int WRESP_CYCLES  = (T_WRESP_US * 1000) / CLK_PERIOD_NS;
    localparam int WSC_CYCLES    = (T_WSC_US * 1000) / CLK_PERIOD_NS;
    localparam int PROG_CYCLES   = (T_PROG_US * 1000) / CLK_PERIOD_NS;
    localparam int CNT_W         = 20;

    // Frame payload lengths with the CRC already stripped.
    localparam logic [5:0] CMD_BITS  = 6'h0c;
    localparam logic [5:0] SS_BITS   = 6'h26;
    localparam logic [5:0] DATA_BITS = 6'h20;

    // Command codes and field values.
    localparam logic [4:0] SS_CODE       = 5'h00;
    localparam logic [3:0] OP_READ_PAGE  = 4'hc;
    localparam logic [3:0] OP_READ_BLOCK = 4'hd;
    localparam logic [3:0] OP_WRITE_PAGE = 4'h8;
    localparam logic [3:0] OP_WRITE_BLK  = 4'h9;
    localparam logic [1:0] LAST_IN_BLOCK = 2'h3;
    localparam logic [4:0] ACK_LAST_BIT  = 5'h01;
    localparam logic [4:0] WORD_LAST_BIT = 5'h1f;
    localparam int         PAGES         = 64;

    // Identifier of this tag; the value is arbitrary.
    localparam logic [31:0] TAG_ID_DEFAULT = 32'h1234_5678;

    typedef enum logic [1:0] {
        PR_INIT     = 2'b00,
        PR_SELECTED = 2'b01,
        PR_SILENT   = 2'b10
    } proto_t;

    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_RESP_WAIT = 3'b001,
        ST_SOF       = 3'b010,
        ST_BITS      = 3'b011,
        ST_CRC       = 3'b100,
        ST_DATA_WAIT = 3'b101,
        ST_PROG      = 3'b110
    } seq_t;
endpackage

// ---- src/tag_cmd_handler.sv ----
// Tag-side handler for silencing, page/block read and page/block write.
//
// Contract
// - Own-identifier silencing frame in init goes silent.
// - Silencing reply is start-of-frame then acknowledge 01.
// - Reads accepted only while selected.
// - Page read returns SOF, 32 bits, CRC.
// - Block read streams to block end, then CRC.
// - Least significant byte first, bytes MSB first.
// - Writes accepted only while selected.
// - Write-page command acknowledged before data phase.
// - After programming time, acknowledge the programmed page.
// - Write-block command acknowledged with SOF and 01.
// - Each block page programmed and acknowledged separately.
// - Silent tag answers nothing until power-up.
`timescale 1ns/1ps
`default_nettype none
module tag_cmd_handler #(
    parameter int          WRESP = tag_cmd_pkg::WRESP_CYCLES,
    parameter int          WSC   = tag_cmd_pkg::WSC_CYCLES,
    parameter int          PROG  = tag_cmd_pkg::PROG_CYCLES,
    parameter logic [31:0] TAG_ID = tag_cmd_pkg::TAG_ID_DEFAULT
) (
    // Clock and power-up reset
    input  wire logic clock_i,
    input  wire logic rst_i,
    // Decoded reader frames
    input  wire logic rx_bit_i,
    input  wire logic rx_valid_i,
    input  wire logic rx_eof_i,
    input  wire logic rx_crc_ok_i,
    // Select or select-plus-challenge completed elsewhere
    input  wire logic sel_grant_i,
    // Reply stream to the encoder
    output logic      tx_sof_o,
    output logic      tx_valid_o,
    output logic      tx_bit_o,
    output logic      tx_crc_o,
    output logic      tx_manchester_o,
    // Status
    output logic      selected_o,
    output logic      silent_o,
    output logic      busy_o
);
    import tag_cmd_pkg::*;

    // Stream order: bytes go out LSB byte first, each byte MSB first.
    function automatic logic [4:0] bit_pos(input logic [4:0] i);
        bit_pos = {i[4:3], ~i[2:0]};
    endfunction

    function automatic logic [31:0] reorder(input logic [31:0] s);
        logic [31:0] w;
        w = '0;
        for (int b = 0; b < 4; b++)
        begin
            w[8*b +: 8] = s[31-8*b -: 8];
        end
        reorder = w;
    endfunction

    logic [31:0]      mem [PAGES];
    proto_t           proto;
    seq_t             state;
    logic [39:0]      rx_sh;
    logic [5:0]       rx_cnt;
    logic [31:0]      wr_data;
    logic [CNT_W-1:0] cnt;
    logic [5:0]       addr;
    logic [5:0]       page;
    logic [4:0]       bit_cnt;
    logic             tx_ack;
    logic             cmd_block;
    logic             cmd_write;
    logic             cmd_ss;
    logic             pend_data;

    logic       frame_ok;
    logic       ss_hit;
    logic       cmd_hit;
    logic       data_hit;
    logic [3:0] op;
    logic       op_known;

    assign frame_ok = rx_eof_i && rx_crc_ok_i;
    assign op       = rx_sh[11:8];
    assign op_known = op == OP_READ_PAGE || op == OP_READ_BLOCK ||
                      op == OP_WRITE_PAGE || op == OP_WRITE_BLK;
    assign ss_hit   = frame_ok && state == ST_IDLE && proto == PR_INIT &&
                      rx_cnt == SS_BITS && rx_sh[37:33] == SS_CODE &&
                      !rx_sh[0] && reorder(rx_sh[32:1]) == TAG_ID;
    // An address above the top page is dropped without a reply.
    assign cmd_hit  = frame_ok && state == ST_IDLE &&
                      proto == PR_SELECTED && rx_cnt == CMD_BITS &&
                      op_known && rx_sh[7:6] == 2'h0;
    assign data_hit = frame_ok && state == ST_DATA_WAIT && cnt == '0 &&
                      rx_cnt == DATA_BITS;

    // Receive shifter; the count saturates so long frames never alias.
    always_ff @(posedge clock_i)
    begin
        if (rst_i || rx_eof_i)
        begin
            rx_cnt <= '0;
            rx_sh  <= '0;
        end
        else if (rx_valid_i)
        begin
            rx_sh <= {rx_sh[38:0], rx_bit_i};
            if (rx_cnt != 6'h3f)
                rx_cnt <= rx_cnt + 6'h01;
        end
    end

    // Protocol state; only power-up leaves the silent state.
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            proto <= PR_INIT;
        else if (ss_hit)
            proto <= PR_SILENT;
        else if (sel_grant_i && proto != PR_SILENT)
            proto <= PR_SELECTED;
    end

    // Page store written at the end of the programming time.
    always_ff @(posedge clock_i)
    begin
        if (!rst_i && state == ST_PROG && cnt == '0)
            mem[page] <= wr_data;
    end

    // Command sequencer and reply stream.
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            state      <= ST_IDLE;
            cnt        <= '0;
            addr       <= '0;
            page       <= '0;
            bit_cnt    <= '0;
            tx_ack     <= 1'b0;
            cmd_block  <= 1'b0;
            cmd_write  <= 1'b0;
            cmd_ss     <= 1'b0;
            pend_data  <= 1'b0;
            wr_data    <= '0;
            tx_sof_o   <= 1'b0;
            tx_valid_o <= 1'b0;
            tx_bit_o   <= 1'b0;
            tx_crc_o   <= 1'b0;
        end
        else
        begin
            tx_sof_o <= 1'b0;
            tx_crc_o <= 1'b0;
            unique case (state)
                ST_IDLE:
                begin
                    cnt <= CNT_W'(WRESP - 1);
                    if (ss_hit)
                    begin
                        state     <= ST_RESP_WAIT;
                        tx_ack    <= 1'b1;
                        cmd_ss    <= 1'b1;
                        cmd_write <= 1'b0;
                        pend_data <= 1'b0;
                    end
                    else if (cmd_hit)
                    begin
                        state     <= ST_RESP_WAIT;
                        cmd_ss    <= 1'b0;
                        addr      <= rx_sh[5:0];
                        page      <= rx_sh[5:0];
                        // Odd codes are the block variants of read and write.
                        cmd_block <= op[0];
                        cmd_write <= !op[2];
                        tx_ack    <= !op[2];
                        pend_data <= !op[2];
                    end
                end
                ST_RESP_WAIT:
                begin
                    cnt <= cnt - 1'b1;
                    if (cnt == '0)
                    begin
                        state    <= ST_SOF;
                        tx_sof_o <= 1'b1;
                    end
                end
                ST_SOF:
                begin
                    state      <= ST_BITS;
                    bit_cnt    <= '0;
                    tx_valid_o <= 1'b1;
                    tx_bit_o   <= tx_ack ? 1'b0 : mem[page][bit_pos(5'h00)];
                end
                ST_BITS:
                begin
                    if (bit_cnt != (tx_ack ? ACK_LAST_BIT : WORD_LAST_BIT))
                    begin
                        bit_cnt  <= bit_cnt + 5'h01;
                        tx_bit_o <= tx_ack ? 1'b1 :
                                    mem[page][bit_pos(bit_cnt + 5'h01)];
                    end
                    else if (tx_ack)
                    begin
                        tx_valid_o <= 1'b0;
                        cnt        <= CNT_W'(WSC - 1);
                        state      <= pend_data ? ST_DATA_WAIT : ST_IDLE;
                    end
                    else if (cmd_block && page[1:0] != LAST_IN_BLOCK)
                    begin
                        page     <= page + 6'h01;
                        bit_cnt  <= '0;
                        tx_bit_o <= mem[page + 6'h01][bit_pos(5'h00)];
                    end
                    else
                    begin
                        tx_valid_o <= 1'b0;
                        tx_crc_o   <= 1'b1;
                        state      <= ST_CRC;
                    end
                end
                ST_CRC:
                    state <= ST_IDLE;
                ST_DATA_WAIT:
                begin
                    if (cnt != '0)
                        cnt <= cnt - 1'b1;
                    if (data_hit)
                    begin
                        wr_data <= reorder(rx_sh[31:0]);
                        cnt     <= CNT_W'(PROG - 1);
                        state   <= ST_PROG;
                    end
                    else if (rx_eof_i)
                        state <= ST_IDLE;
                end
                ST_PROG:
                begin
                    cnt <= cnt - 1'b1;
                    if (cnt == '0)
                    begin
                        state     <= ST_SOF;
                        tx_sof_o  <= 1'b1;
                        tx_ack    <= 1'b1;
                        pend_data <= cmd_block &&
                                     page[1:0] != LAST_IN_BLOCK;
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
            if (state == ST_PROG && cnt == '0 && cmd_block &&
                page[1:0] != LAST_IN_BLOCK)
                page <= page + 6'h01;
        end
    end

    // Status outputs, all registered.
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            selected_o      <= 1'b0;
            silent_o        <= 1'b0;
            busy_o          <= 1'b0;
            tx_manchester_o <= 1'b0;
        end
        else
        begin
            selected_o      <= proto == PR_SELECTED;
            silent_o        <= proto == PR_SILENT;
            busy_o          <= state != ST_IDLE;
            tx_manchester_o <= 1'b1;
        end
    end

    // Bits sent since the last start-of-frame, for the checks below.
    logic [7:0] tx_bits;
    always_ff @(posedge clock_i)
    begin
        if (rst_i || tx_sof_o)
            tx_bits <= '0;
        else if (tx_valid_o)
            tx_bits <= tx_bits + 8'h01;
    end

    sequence ack_shape;
        tx_valid_o && !tx_bit_o ##1 tx_valid_o && tx_bit_o ##1 !tx_valid_o;
    endsequence

    a_ss_silent: assert property (@(posedge clock_i) disable iff (rst_i)
        ss_hit |=> proto == PR_SILENT)
        else $error("silencing frame did not silence the tag");
    a_ack_shape: assert property (@(posedge clock_i) disable iff (rst_i)
        tx_sof_o && tx_ack |=> ack_shape)
        else $error("acknowledge is not 01 after start-of-frame");
    a_read_gate: assert property (@(posedge clock_i) disable iff (rst_i)
        state == ST_IDLE && rx_eof_i && proto != PR_SELECTED &&
        rx_cnt == CMD_BITS |=> state == ST_IDLE)
        else $error("memory command taken while not selected");
    a_page_len: assert property (@(posedge clock_i) disable iff (rst_i)
        tx_crc_o && !cmd_block |-> tx_bits == 8'd32)
        else $error("page read did not send 32 bits");
    a_block_len: assert property (@(posedge clock_i) disable iff (rst_i)
        tx_crc_o && cmd_block |->
        tx_bits == 8'({3'h4 - {1'b0, addr[1:0]}, 5'h00}))
        else $error("block read length wrong");
    a_byte_order: assert property (@(posedge clock_i) disable iff (rst_i)
        $rose(tx_valid_o) && !tx_ack |-> tx_bit_o == mem[page][7])
        else $error("first sent bit is not bit 7 of byte zero");
    a_write_gate: assert property (@(posedge clock_i) disable iff (rst_i)
        state == ST_RESP_WAIT && $past(state) == ST_IDLE && cmd_write &&
        !cmd_ss |-> $past(proto) == PR_SELECTED)
        else $error("write taken while not selected");
    a_wr_data_phase: assert property (@(posedge clock_i) disable iff (rst_i)
        state == ST_BITS && tx_ack && bit_cnt == ACK_LAST_BIT && pend_data
        |=> state == ST_DATA_WAIT)
        else $error("no data phase after write acknowledge");
    a_prog_ack: assert property (@(posedge clock_i) disable iff (rst_i)
        state == ST_PROG && cnt == '0 |=> tx_sof_o && tx_ack ##1
        ack_shape)
        else $error("programming not confirmed by acknowledge");
    a_silent_quiet: assert property (@(posedge clock_i) disable iff (rst_i)
        proto == PR_SILENT && state == ST_IDLE |=> state == ST_IDLE)
        else $error("silent tag started a reply");
    a_bad_crc: assert property (@(posedge clock_i) disable iff (rst_i)
        state == ST_IDLE && rx_eof_i && !rx_crc_ok_i |=>
        state == ST_IDLE)
        else $error("frame with bad CRC was answered");
endmodule // tag_cmd_handler
`default_nettype wire

// ---- verif/reader_model.sv ----
// Reader side model that sends decoded command and data frames to the tag.
`timescale 1ns/1ps
`default_nettype none
module reader_model (
    // Clock
    input  wire logic clock_i,
    // Frame bus towards the tag
    output logic      rx_bit_o,
    output logic      rx_valid_o,
    output logic      rx_eof_o,
    output logic      rx_crc_ok_o
);
    initial
    begin
        rx_bit_o    = 1'b0;
        rx_valid_o  = 1'b0;
        rx_eof_o    = 1'b0;
        rx_crc_ok_o = 1'b0;
    end

    // Sends n bits, first on air first; crc_good is the front end's verdict.
    task automatic send(input logic [63:0] bits, input int n,
                        input logic crc_good);
        for (int i = n - 1; i >= 0; i--)
        begin
            @(negedge clock_i);
            rx_bit_o   = bits[i];
            rx_valid_o = 1'b1;
        end
        @(negedge clock_i);
        // The idle line shows the inverse so a stale bit never passes.
        rx_bit_o    = ~rx_bit_o;
        rx_valid_o  = 1'b0;
        rx_eof_o    = 1'b1;
        rx_crc_ok_o = crc_good;
        @(negedge clock_i);
        rx_eof_o    = 1'b0;
        rx_crc_ok_o = ~crc_good;
    endtask
endmodule // reader_model
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking testbench for the tag memory command handler.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import tag_cmd_pkg::*;
    localparam int WR = 3;
    localparam int WS = 3;
    localparam int PR = 5;
    localparam logic [31:0] ID = TAG_ID_DEFAULT;
    logic clock_i = 1'b0;
    logic rst_i   = 1'b1;
    logic sel_grant_i = 1'b0;
    logic rx_bit_i, rx_valid_i, rx_eof_i, rx_crc_ok_i;
    logic tx_sof_o, tx_valid_o, tx_bit_o, tx_crc_o, tx_manchester_o;
    logic selected_o, silent_o, busy_o;
    int   n_errors = 0;
    int   samples_checked = 0;

    always #5 clock_i = ~clock_i;

    reader_model reader_model_inst (.clock_i(clock_i), .rx_bit_o(rx_bit_i),
        .rx_valid_o(rx_valid_i), .rx_eof_o(rx_eof_i),
        .rx_crc_ok_o(rx_crc_ok_i));

    tag_cmd_handler #(.WRESP(WR), .WSC(WS), .PROG(PR)) tag_cmd_handler_inst (
        .clock_i(clock_i), .rst_i(rst_i), .rx_bit_i(rx_bit_i),
        .rx_valid_i(rx_valid_i), .rx_eof_i(rx_eof_i),
        .rx_crc_ok_i(rx_crc_ok_i), .sel_grant_i(sel_grant_i),
        .tx_sof_o(tx_sof_o), .tx_valid_o(tx_valid_o), .tx_bit_o(tx_bit_o),
        .tx_crc_o(tx_crc_o), .tx_manchester_o(tx_manchester_o),
        .selected_o(selected_o), .silent_o(silent_o), .busy_o(busy_o));

    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1)
        begin
            n_errors++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask

    task automatic give_verdict();
        if (n_errors == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic power_up();
        rst_i = 1'b1;
        repeat (2) @(negedge clock_i);
        rst_i = 1'b0;
        @(negedge clock_i);
        check(tx_manchester_o === 1'b1, "reply coding not Manchester");
    endtask

    task automatic grant();
        @(negedge clock_i);
        sel_grant_i = 1'b1;
        @(negedge clock_i);
        sel_grant_i = 1'b0;
        // The status output is registered one edge behind the state.
        @(negedge clock_i);
    endtask

    // Waits for start-of-frame within lo..hi cycles, then checks n bits.
    task automatic expect_reply(input int lo, input int hi, input int n,
                                input logic [127:0] exp, input logic crc);
        int k;
        k = 0;
        while (tx_sof_o !== 1'b1 && k <= hi)
        begin
            @(negedge clock_i);
            k++;
        end
        check(k >= lo && k <= hi, "reply start late or early");
        for (int i = n - 1; i >= 0; i--)
        begin
            @(negedge clock_i);
            check(tx_valid_o === 1'b1 && tx_bit_o === exp[i], "reply bit");
        end
        @(negedge clock_i);
        check(tx_valid_o === 1'b0 && tx_crc_o === crc, "reply end");
    endtask

    task automatic no_reply(input int cycles);
        for (int i = 0; i < cycles; i++)
        begin
            @(negedge clock_i);
            check(tx_sof_o === 1'b0 && tx_valid_o === 1'b0, "no reply");
        end
    endtask

    // Sends one page of data after the setup wait and expects its ack.
    task automatic write_data(input logic [31:0] s);
        repeat (WS + 1) @(negedge clock_i);
        reader_model_inst.send({32'h0, s}, 32, 1'b1);
        expect_reply(PR, PR + 2, 2, 128'h1, 1'b0);
    endtask

    task automatic t_unselected();
        power_up();
        reader_model_inst.send({4'hc, 8'h05}, 12, 1'b1);
        no_reply(20);
        reader_model_inst.send({4'h8, 8'h05}, 12, 1'b1);
        no_reply(20);
        check(selected_o === 1'b0, "selected without grant");
    endtask

    task automatic t_write_read_page();
        grant();
        check(selected_o === 1'b1, "grant not taken");
        reader_model_inst.send({4'h8, 8'h05}, 12, 1'b1);
        expect_reply(WR, WR, 2, 128'h1, 1'b0);
        write_data(32'ha5c3_0f81);
        reader_model_inst.send({4'hc, 8'h05}, 12, 1'b1);
        expect_reply(WR, WR, 32, 128'ha5c3_0f81, 1'b1);
    endtask

    task automatic t_block();
        reader_model_inst.send({4'h9, 8'h06}, 12, 1'b1);
        expect_reply(WR, WR, 2, 128'h1, 1'b0);
        write_data(32'h1e2d_3c4b);
        write_data(32'h8796_a5b4);
        repeat (2) @(negedge clock_i);
        check(busy_o === 1'b0, "block write overran block end");
        reader_model_inst.send({4'hd, 8'h06}, 12, 1'b1);
        expect_reply(WR, WR, 64, 128'h1e2d_3c4b_8796_a5b4, 1'b1);
    endtask

    task automatic t_refused();
        reader_model_inst.send({4'hc, 8'h05}, 12, 1'b0);
        no_reply(20);
        reader_model_inst.send({4'hc, 8'h40}, 12, 1'b1);
        no_reply(20);
    endtask

    task automatic t_silence();
        power_up();
        reader_model_inst.send({5'h00, ~ID[7:0], ID[15:8], ID[23:16],
                                ID[31:24], 1'b0}, 38, 1'b1);
        no_reply(20);
        check(silent_o === 1'b0, "silenced by foreign identifier");
        reader_model_inst.send({5'h00, ID[7:0], ID[15:8], ID[23:16],
                                ID[31:24], 1'b0}, 38, 1'b1);
        expect_reply(WR, WR, 2, 128'h1, 1'b0);
        check(silent_o === 1'b1, "not silent after own identifier");
        grant();
        check(selected_o === 1'b0, "silent tag became selected");
        reader_model_inst.send({4'hc, 8'h05}, 12, 1'b1);
        no_reply(20);
    endtask

    initial
    begin
        t_unselected();
        t_write_read_page();
        t_block();
        t_refused();
        t_silence();
        give_verdict();
    end

    // The whole sequence needs well under 2000 cycles.
    initial
    begin
        #100us;
        n_errors++;
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
